/* can_error_and_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module can_error_and_status_regs
  import can_err_stat_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire logic [1:0]              reg_sel,
  input  wire logic [31:0]             reg_wdata,
  output logic      [31:0]             reg_rdata_r,
  output logic                         reg_rvalid_r,
  input  wire logic                    ctl_wr_en,
  input  wire logic                    ctl_soft_reset,
  input  wire logic                    ctl_core_enable,
  input  wire logic                    filter_use_wr_en,
  input  wire logic [FILTER_COUNT-1:0] filter_use_wdata,
  input  wire logic                    filter_update_done,
  input  wire logic                    tx_fifo_full,
  input  wire logic                    priority_buffer_full,
  input  wire logic                    tx_err_inc_en,
  input  wire logic [3:0]              tx_err_inc_amt,
  input  wire logic                    tx_err_dec,
  input  wire logic                    rx_err_inc_en,
  input  wire logic [3:0]              rx_err_inc_amt,
  input  wire logic                    rx_err_dec,
  input  wire logic                    recessive_run_11,
  input  wire logic                    bit_check_en,
  input  wire logic                    bit_driven,
  input  wire logic                    bit_sampled,
  input  wire logic                    ack_fault_evt,
  input  wire logic                    stuff_fault_evt,
  input  wire logic                    form_fault_evt,
  input  wire logic                    checksum_fault_evt,
  input  wire logic                    checksum_delim_bad,
  output logic      [1:0]              fault_confinement_state_r
);

  // Position p of the word maps to vector bit 31-p
  function automatic int vbit(input int pos);
    vbit = 31 - pos;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control decode

  logic soft_reset_hit;
  logic disable_hit;
  logic enable_hit;
  logic core_enable_r;
  logic core_enable_nxt;

  always_comb
  begin
    soft_reset_hit  = ctl_wr_en & ctl_soft_reset;
    disable_hit     = ctl_wr_en & ~ctl_soft_reset & ~ctl_core_enable;
    enable_hit      = ctl_wr_en & ~ctl_soft_reset & ctl_core_enable;
    core_enable_nxt = core_enable_r;
    if (soft_reset_hit || disable_hit)
      core_enable_nxt = 1'b0;
    else if (enable_hit)
      core_enable_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      core_enable_r <= 1'b0;
    else
      core_enable_r <= core_enable_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error counters and fault-confinement state

  fault_state_e state_r;
  fault_state_e state_nxt;
  logic [7:0]   tx_error_count_r;
  logic [7:0]   tx_error_count_nxt;
  logic [7:0]   rx_error_count_r;
  logic [7:0]   rx_error_count_nxt;
  logic [8:0]   tx_sum;
  logic [8:0]   rx_sum;

  always_comb
  begin
    state_nxt          = state_r;
    tx_error_count_nxt = tx_error_count_r;
    rx_error_count_nxt = rx_error_count_r;
    tx_sum = {1'b0, tx_error_count_r} + {5'h00, tx_err_inc_en ? tx_err_inc_amt : 4'h0};
    rx_sum = {1'b0, rx_error_count_r} + {5'h00, rx_err_inc_en ? rx_err_inc_amt : 4'h0};
    if (tx_err_dec && !tx_err_inc_en && tx_error_count_r != COUNT_RESET)
      tx_sum = {1'b0, tx_error_count_r - 8'h01};
    if (rx_err_dec && !rx_err_inc_en && rx_error_count_r != COUNT_RESET)
      rx_sum = {1'b0, rx_error_count_r - 8'h01};
    case (state_r)
      FC_CONFIG:
      begin
        // Leave config on the enabling edge so 00 never shows beside a cleared config bit
        if (core_enable_nxt)
          state_nxt = FC_ACTIVE;
      end
      FC_ACTIVE, FC_PASSIVE:
      begin
        if (tx_sum[8])
        begin
          // Entering bus-off wipes both counts
          state_nxt          = FC_BUS_OFF;
          tx_error_count_nxt = COUNT_RESET;
          rx_error_count_nxt = COUNT_RESET;
        end
        else
        begin
          tx_error_count_nxt = tx_sum[7:0];
          // Rx count saturates; only tx can drive bus-off
          rx_error_count_nxt = rx_sum[8] ? COUNT_MAX : rx_sum[7:0];
          if (tx_sum[7:0] >= PASSIVE_LEVEL || rx_sum[8] || rx_sum[7:0] >= PASSIVE_LEVEL)
            state_nxt = FC_PASSIVE;
          else
            state_nxt = FC_ACTIVE;
        end
      end
      FC_BUS_OFF:
      begin
        // Rx count doubles as the recovery run counter
        if (recessive_run_11)
        begin
          if (rx_error_count_r == RECOVERY_LAST_RUN)
          begin
            state_nxt          = FC_ACTIVE;
            tx_error_count_nxt = COUNT_RESET;
            rx_error_count_nxt = COUNT_RESET;
          end
          else
            rx_error_count_nxt = rx_error_count_r + 8'h01;
        end
      end
      default:
        state_nxt = FC_CONFIG;
    endcase
    if (!core_enable_nxt)
    begin
      state_nxt          = FC_CONFIG;
      tx_error_count_nxt = COUNT_RESET;
      rx_error_count_nxt = COUNT_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r                   <= FC_CONFIG;
      tx_error_count_r          <= COUNT_RESET;
      rx_error_count_r          <= COUNT_RESET;
      fault_confinement_state_r <= FC_CONFIG;
    end
    else
    begin
      state_r                   <= state_nxt;
      tx_error_count_r          <= tx_error_count_nxt;
      rx_error_count_r          <= rx_error_count_nxt;
      fault_confinement_state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky bus error flags

  logic [FLAG_COUNT-1:0] flag_set;
  logic [FLAG_COUNT-1:0] flag_q;
  logic [FLAG_COUNT-1:0] flag_clr;
  logic                  flag_wr;
  logic                  flag_clr_all;

  always_comb
  begin
    flag_wr      = reg_wr_en & (reg_sel == IDX_BUS_ERROR_FLAGS);
    flag_clr_all = disable_hit | soft_reset_hit;
    // Index order: ack, bit, stuff, form, checksum
    flag_set[0]  = ack_fault_evt;
    flag_set[1]  = bit_check_en & (bit_driven != bit_sampled);
    flag_set[2]  = stuff_fault_evt;
    flag_set[3]  = form_fault_evt | (checksum_fault_evt & checksum_delim_bad);
    flag_set[4]  = checksum_fault_evt & ~checksum_delim_bad;
    flag_clr[0]  = flag_wr & reg_wdata[vbit(POS_ACK_FAULT)];
    flag_clr[1]  = flag_wr & reg_wdata[vbit(POS_BIT_MISMATCH)];
    flag_clr[2]  = flag_wr & reg_wdata[vbit(POS_STUFF_FAULT)];
    flag_clr[3]  = flag_wr & reg_wdata[vbit(POS_FORM_FAULT)];
    flag_clr[4]  = flag_wr & reg_wdata[vbit(POS_CHECKSUM_FAULT)];
  end

  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_evt (flag_set[gi]),
        .clr_one (flag_clr[gi]),
        .clr_all (flag_clr_all),
        .flag_r  (flag_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance-filter busy

  logic filter_busy_r;
  logic filter_busy_nxt;

  generate
    if (FILTER_COUNT != 0)
    begin : g_filter_busy
      always_comb
      begin
        filter_busy_nxt = filter_busy_r;
        if (filter_update_done)
          filter_busy_nxt = 1'b0;
        // A disabling write arriving with done keeps the bit set
        if (filter_use_wr_en && (filter_use_wdata != {FILTER_COUNT{1'b1}}))
          filter_busy_nxt = 1'b1;
        if (soft_reset_hit)
          filter_busy_nxt = 1'b0;
      end
    end
    else
    begin : g_no_filter
      always_comb
      begin
        filter_busy_nxt = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      filter_busy_r <= 1'b0;
    else
      filter_busy_r <= filter_busy_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rdata_nxt;
  logic [31:0] counter_word;
  logic [31:0] flag_word;
  logic [31:0] state_word;

  always_comb
  begin
    counter_word = ERROR_COUNTER_RESET;
    counter_word[vbit(POS_RX_COUNT_LO) -: 8] = rx_error_count_r;
    counter_word[vbit(POS_TX_COUNT_LO) -: 8] = tx_error_count_r;

    flag_word = ERROR_FLAGS_RESET;
    flag_word[vbit(POS_ACK_FAULT)]      = flag_q[0];
    flag_word[vbit(POS_BIT_MISMATCH)]   = flag_q[1];
    flag_word[vbit(POS_STUFF_FAULT)]    = flag_q[2];
    flag_word[vbit(POS_FORM_FAULT)]     = flag_q[3];
    flag_word[vbit(POS_CHECKSUM_FAULT)] = flag_q[4];

    state_word = 32'h0000_0000;
    state_word[vbit(POS_FILTER_UPDATE_BUSY)] = filter_busy_r;
    state_word[vbit(POS_TX_FIFO_FULL)]       = tx_fifo_full;
    state_word[vbit(POS_PRIORITY_BUF_FULL)]  = priority_buffer_full;
    state_word[vbit(POS_FAULT_STATE_HI)]     = state_r[1];
    state_word[vbit(POS_FAULT_STATE_LO)]     = state_r[0];
    state_word[vbit(POS_COUNTER_WARNING)]    = (tx_error_count_r >= WARNING_LEVEL) ||
                                               (rx_error_count_r >= WARNING_LEVEL);
    state_word[vbit(POS_CONFIG_MODE)]        = ~core_enable_r;

    // Counter word has no write path at all
    case (reg_sel)
      IDX_ERROR_COUNTER_VALUES: rdata_nxt = counter_word;
      IDX_BUS_ERROR_FLAGS:      rdata_nxt = flag_word;
      IDX_CONTROLLER_STATE:     rdata_nxt = state_word;
      default:                  rdata_nxt = 32'h0000_0000;
    endcase
    if (!reg_rd_en)
      rdata_nxt = reg_rdata_r;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_r  <= 32'h0000_0000;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rdata_r  <= rdata_nxt;
      reg_rvalid_r <= reg_rd_en;
    end
  end

endmodule

`default_nettype wire

/* can_err_stat_pkg.sv */
package can_err_stat_pkg;

  // Register indices on the local register port
  localparam logic [1:0] IDX_ERROR_COUNTER_VALUES = 2'h0;
  localparam logic [1:0] IDX_BUS_ERROR_FLAGS      = 2'h1;
  localparam logic [1:0] IDX_CONTROLLER_STATE     = 2'h2;

  // Field positions, most-significant-first numbering
  localparam int POS_RX_COUNT_LO        = 16;
  localparam int POS_TX_COUNT_LO        = 24;
  localparam int POS_ACK_FAULT          = 27;
  localparam int POS_BIT_MISMATCH       = 28;
  localparam int POS_STUFF_FAULT        = 29;
  localparam int POS_FORM_FAULT         = 30;
  localparam int POS_CHECKSUM_FAULT     = 31;
  localparam int POS_FILTER_UPDATE_BUSY = 20;
  localparam int POS_TX_FIFO_FULL       = 21;
  localparam int POS_PRIORITY_BUF_FULL  = 22;
  localparam int POS_FAULT_STATE_HI     = 23;
  localparam int POS_FAULT_STATE_LO     = 24;
  localparam int POS_COUNTER_WARNING    = 25;
  localparam int POS_CONFIG_MODE        = 31;

  // Reset values and thresholds
  localparam logic [31:0] ERROR_COUNTER_RESET = 32'h0000_0000;
  localparam logic [31:0] ERROR_FLAGS_RESET   = 32'h0000_0000;
  localparam logic [7:0]  COUNT_RESET         = 8'h00;
  localparam logic [7:0]  WARNING_LEVEL       = 8'h60;
  localparam logic [7:0]  PASSIVE_LEVEL       = 8'h80;
  localparam logic [7:0]  RECOVERY_LAST_RUN   = 8'h7F;
  localparam logic [7:0]  COUNT_MAX           = 8'hFF;

  localparam int FILTER_COUNT = 4;
  localparam int FLAG_COUNT   = 5;

  // Fault-confinement states, Gray coded
  typedef enum logic [1:0] {
    FC_CONFIG  = 2'b00,
    FC_ACTIVE  = 2'b01,
    FC_PASSIVE = 2'b11,
    FC_BUS_OFF = 2'b10
  } fault_state_e;

endpackage

/* sticky_flag.sv */
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic set_evt,
  input  wire logic clr_one,
  input  wire logic clr_all,
  output logic      flag_r
);

  logic flag_nxt;

  always_comb
  begin
    // Set beats any clear in the same cycle
    flag_nxt = set_evt | (flag_r & ~clr_one & ~clr_all);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

endmodule

`default_nettype wire

/* can_err_stat_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module can_err_stat_asserts
  import can_err_stat_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_rd_en,
  input wire logic [1:0]  reg_sel,
  input wire logic [31:0] reg_rdata_r,
  input wire logic        reg_rvalid_r,
  input wire logic        ctl_wr_en,
  input wire logic        ctl_soft_reset,
  input wire logic        ctl_core_enable,
  input wire logic        tx_fifo_full,
  input wire logic        priority_buffer_full,
  input wire logic [1:0]  fault_confinement_state_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (reg_rd_en |=> reg_rvalid_r)
    else $error("read not answered");
  rd_pulse_a: assert property (!reg_rd_en |=> !reg_rvalid_r)
    else $error("valid without read");
  rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata_r))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd_en && reg_sel == 2'h3 |=> reg_rdata_r == 32'h0)
    else $error("unmapped index not zero");
  count_fields_a: assert property (
    reg_rd_en && reg_sel == IDX_ERROR_COUNTER_VALUES |=> reg_rdata_r[31:16] == 16'h0)
    else $error("counter reserved bits set");
  flag_fields_a: assert property (
    reg_rd_en && reg_sel == IDX_BUS_ERROR_FLAGS |=> reg_rdata_r[31:5] == 27'h0)
    else $error("flag reserved bits set");
  state_word_a: assert property (
    reg_rd_en && reg_sel == IDX_CONTROLLER_STATE |=> reg_rdata_r[31:12] == 20'h0
    && reg_rdata_r[10:7] == {$past(tx_fifo_full), $past(priority_buffer_full),
    $past(fault_confinement_state_r)}
    && reg_rdata_r[0] == ($past(fault_confinement_state_r) == FC_CONFIG))
    else $error("state word mismatch");
  config_entry_a: assert property (
    ctl_wr_en && (!ctl_core_enable || ctl_soft_reset) |=> fault_confinement_state_r == FC_CONFIG)
    else $error("disable did not enter config");
  active_entry_a: assert property (
    (ctl_wr_en && ctl_core_enable && !ctl_soft_reset && fault_confinement_state_r == FC_CONFIG)
    ##1 !ctl_wr_en |=> fault_confinement_state_r == FC_ACTIVE)
    else $error("enable did not reach active");
endmodule
`default_nettype wire

/* can_error_and_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module can_error_and_status_regs_bench
  import can_err_stat_pkg::*;
;
  logic clk, sys_rst, reg_wr_en, reg_rd_en, reg_rvalid_r, ctl_wr_en, ctl_soft_reset;
  logic ctl_core_enable, filter_use_wr_en, filter_update_done, tx_fifo_full;
  logic priority_buffer_full, tx_err_inc_en, tx_err_dec, rx_err_inc_en, rx_err_dec;
  logic recessive_run_11, bit_check_en, bit_driven, bit_sampled, ack_fault_evt;
  logic stuff_fault_evt, form_fault_evt, checksum_fault_evt, checksum_delim_bad, busy;
  logic [1:0]  reg_sel, fault_confinement_state_r, st;
  logic [3:0]  filter_use_wdata, tx_err_inc_amt, rx_err_inc_amt;
  logic [4:0]  flg;
  logic [31:0] reg_wdata, reg_rdata_r;
  int          tx_error_count, rx_error_count, miscompares, total_checks, seed, i;

  can_error_and_status_regs i_can_error_and_status_regs (.*);
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] cnt();
    return {16'h0, 8'(rx_error_count), 8'(tx_error_count)};
  endfunction
  function automatic logic [31:0] sw();
    return {20'h0, busy, tx_fifo_full, priority_buffer_full, st,
            (tx_error_count >= 96 || rx_error_count >= 96), 5'h0, st == 2'b00};
  endfunction
  task automatic idle();
    {reg_wr_en, reg_rd_en, ctl_wr_en, filter_use_wr_en, filter_update_done, tx_err_inc_en,
     tx_err_dec, rx_err_inc_en, rx_err_dec, recessive_run_11, bit_check_en, ack_fault_evt,
     stuff_fault_evt, form_fault_evt, checksum_fault_evt, checksum_delim_bad} = '0;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Idle edge between transfers so no strobe drops and rises in one step
  task automatic go();
    step();
    idle();
    step();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e, input string n);
    reg_sel = a;
    reg_rd_en = 1;
    step();
    chk(reg_rvalid_r, 1, "read valid");
    chk(reg_rdata_r, e, n);
    idle();
    step();
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    reg_sel = a;
    reg_wdata = d;
    reg_wr_en = 1;
    go();
  endtask
  task automatic ctl(input logic e, input logic s);
    ctl_wr_en = 1;
    ctl_core_enable = e;
    ctl_soft_reset = s;
    go();
    if (!e || s)
    begin
      {tx_error_count, rx_error_count, flg, st} = '0;
      if (s) busy = 0;
    end
  endtask
  task automatic inc(input int t, input int r);
    tx_err_inc_en = t > 0;
    tx_err_inc_amt = 4'(t);
    rx_err_inc_en = r > 0;
    rx_err_inc_amt = 4'(r);
    go();
    tx_error_count += t;
    rx_error_count += r;
  endtask
  // Event is left pending so a write can share its cycle
  task automatic evt(input int k);
    case (k)
      0: ack_fault_evt = 1;
      1:
      begin
        bit_check_en = 1;
        bit_driven = 1'($random(seed));
        bit_sampled = !bit_driven;
      end
      2: stuff_fault_evt = 1;
      3: form_fault_evt = 1;
      default: checksum_fault_evt = 1;
    endcase
    flg[4-k] = 1;
  endtask
  task automatic note(input string n);
    $display("test %s done", n);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the scripted run
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
  initial
  begin
    seed = 59154;
    idle();
    {reg_sel, reg_wdata, filter_use_wdata, tx_fifo_full, priority_buffer_full} = '0;
    {ctl_core_enable, ctl_soft_reset, bit_driven, bit_sampled, tx_err_inc_amt} = '0;
    rx_err_inc_amt = 0;
    {tx_error_count, rx_error_count, flg, st, busy, miscompares, total_checks} = '0;
    sys_rst = 1;
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    tx_fifo_full = 0;
    priority_buffer_full = 0;
    rd(0, 0, "counters");
    rd(1, 0, "flags");
    rd(2, sw(), "state");
    rd(3, 0, "unmapped");
    ctl(1, 0);
    go();
    st = 2'b01;
    chk(fault_confinement_state_r, st, "fc state");
    note("reset");
    for (i = 0; i < 6; i++)
    begin
      inc($random(seed) & 15, $random(seed) & 15);
      tx_fifo_full = 1'($random(seed));
      priority_buffer_full = 1'($random(seed));
      rd(0, cnt(), "counters");
      rd(2, sw(), "state");
    end
    tx_err_dec = 1;
    rx_err_dec = 1;
    go();
    tx_error_count -= tx_error_count > 0;
    rx_error_count -= rx_error_count > 0;
    wr(0, $random(seed));
    rd(0, cnt(), "read only");
    note("counters");
    while (tx_error_count < 95) inc(tx_error_count < 80 ? 15 : 95 - tx_error_count, 0);
    go();
    rd(2, sw(), "below warning");
    inc(1, 0);
    go();
    rd(2, sw(), "warning");
    while (tx_error_count < 128) inc(15, 0);
    st = 2'b11;
    go();
    rd(2, sw(), "passive");
    while (tx_error_count <= 255) inc(15, 0);
    {tx_error_count, rx_error_count} = '0;
    st = 2'b10;
    go();
    rd(0, cnt(), "bus-off counts");
    rd(2, sw(), "bus-off state");
    for (i = 0; i < 127; i++)
    begin
      recessive_run_11 = 1;
      go();
    end
    rx_error_count = 127;
    rd(0, cnt(), "recovery count");
    recessive_run_11 = 1;
    go();
    rx_error_count = 0;
    st = 2'b01;
    go();
    rd(0, cnt(), "recovered");
    rd(2, sw(), "recovered state");
    note("bus-off");
    for (i = 0; i < 5; i++)
    begin
      evt(i);
      go();
      rd(1, {27'h0, flg}, "flag set");
    end
    wr(1, 32'hFFFF_FFE1);
    flg[0] = 0;
    rd(1, {27'h0, flg}, "one cleared");
    evt(2);
    wr(1, 32'h0000_0004);
    rd(1, {27'h0, flg}, "set beats clear");
    wr(1, 32'h0000_001F);
    flg = 0;
    rd(1, 0, "all cleared");
    {bit_check_en, bit_driven, bit_sampled} = 3'b111;
    go();
    rd(1, 0, "no mismatch");
    {checksum_fault_evt, checksum_delim_bad} = 2'b11;
    go();
    flg = 5'b00010;
    rd(1, {27'h0, flg}, "delimiter");
    inc(5, 3);
    ctl(0, 0);
    rd(1, 0, "disable flags");
    rd(0, 0, "disable counts");
    rd(2, sw(), "config");
    note("flags");
    {filter_use_wr_en, filter_use_wdata} = 5'h1F;
    go();
    rd(2, sw(), "all filters used");
    {filter_use_wr_en, filter_use_wdata} = 5'h1E;
    go();
    busy = 1;
    rd(2, sw(), "filter busy");
    filter_update_done = 1;
    go();
    busy = 0;
    rd(2, sw(), "busy cleared");
    ctl(1, 0);
    go();
    inc(7, 2);
    ctl(1, 1);
    rd(0, 0, "soft reset");
    rd(2, sw(), "soft reset state");
    note("filter and soft reset");
    results();
  end
endmodule

bind can_error_and_status_regs can_err_stat_asserts u_chk (.*);
`default_nettype wire
